// ---- design/dual_byte_register_with_scan.sv ----
/*
  Top: two byte registers, boundary-scan test logic on tck, APB registers.
  Assumes tck from a test controller, unrelated to pclk, and APB on pclk.
*/
`timescale 1ns/1ps
module dual_byte_register_with_scan (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic [11:0]                     paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            clk_byte_a,
  input  wire logic                            clk_byte_b,
  input  wire logic                            out_en_n_byte_a,
  input  wire logic                            out_en_n_byte_b,
  input  wire logic [scan_reg_pkg::BYTE_W-1:0] din_byte_a,
  input  wire logic [scan_reg_pkg::BYTE_W-1:0] din_byte_b,
  output logic      [scan_reg_pkg::BYTE_W-1:0] dout_byte_a,
  output logic      [scan_reg_pkg::BYTE_W-1:0] dout_byte_b,
  output logic                                 dout_oe_a,
  output logic                                 dout_oe_b,
  input  wire logic                            tck,
  input  wire logic                            tms,
  input  wire logic                            tdi,
  output logic                                 tdo,
  output logic                                 tdo_oe
);
  import scan_reg_pkg::*;

  // ----------------------------------------------------------------
  // System side: test control shadow on pclk
  // ----------------------------------------------------------------
  test_ctl_s         shadow;
  test_ctl_s         ctl_tck;
  logic              tog_meta;
  logic              tog_sync;
  logic              tog_prev;
  logic              upd_toggle;
  logic [BYTE_W-1:0] q_a;
  logic [BYTE_W-1:0] q_b;
  logic              sys_en_a;
  logic              sys_en_b;

  wire test_drive = (shadow.mode == MODE_EXTEST) |
                    (shadow.mode == MODE_CLAMP);
  wire test_float = (shadow.mode == MODE_HIGHZ);
  wire tog_edge   = tog_sync ^ tog_prev;

  // The tck word is held for several tck periods after each toggle,
  // longer than the three pclk edges the toggle needs to get through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
      shadow   <= CTL_RESET;
    end else begin
      tog_meta <= upd_toggle;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
      if (tog_edge) begin
        shadow <= ctl_tck;
      end
    end
  end

  byte_register u_byte_a (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_pin    (clk_byte_a),
    .oe_n_pin   (out_en_n_byte_a),
    .din_pin    (din_byte_a),
    .test_drive (test_drive),
    .test_float (test_float),
    .test_en    (shadow.en_a),
    .test_val   (shadow.out_a),
    .q          (q_a),
    .sys_en     (sys_en_a),
    .dout       (dout_byte_a),
    .dout_oe    (dout_oe_a)
  );

  byte_register u_byte_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_pin    (clk_byte_b),
    .oe_n_pin   (out_en_n_byte_b),
    .din_pin    (din_byte_b),
    .test_drive (test_drive),
    .test_float (test_float),
    .test_en    (shadow.en_b),
    .test_val   (shadow.out_b),
    .q          (q_b),
    .sys_en     (sys_en_b),
    .dout       (dout_byte_b),
    .dout_oe    (dout_oe_b)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic ctrl_hold;

  // No wait states: every setup is answered in the next cycle
  wire        setup    = psel & ~penable;
  wire        access   = psel & penable & pready;
  wire        hit_ctrl = (paddr == ADDR_CTRL);
  wire        hit_stat = (paddr == ADDR_STATUS);
  wire        hit_a    = (paddr == ADDR_BYTE_A);
  wire        hit_b    = (paddr == ADDR_BYTE_B);
  wire        hit_any  = hit_ctrl | hit_stat | hit_a | hit_b;
  wire [31:0] rd_ctrl  = {31'h00000000, ctrl_hold};
  wire [31:0] rd_stat  = {27'h0000000, shadow.en_b, shadow.en_a,
                          shadow.mode};
  wire [31:0] rd_a     = {23'h000000, q_a};
  wire [31:0] rd_b     = {23'h000000, q_b};
  wire [31:0] rd_mux   = hit_ctrl ? rd_ctrl :
                         hit_stat ? rd_stat :
                         hit_a    ? rd_a    :
                         hit_b    ? rd_b    : 32'h00000000;
  wire        wr_ctrl  = access & pwrite & hit_ctrl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
      ctrl_hold <= CTRL_RESET;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_hold <= pwdata[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Test clock domain: reset and level crossings
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_tck_n;
  logic hold_meta;
  logic hold_sync;

  // Release reaches the tck side only after two tck edges
  always_ff @(posedge tck or negedge presetn) begin
    if (!presetn) begin
      rst_meta  <= 1'b0;
      rst_tck_n <= 1'b0;
    end else begin
      rst_meta  <= 1'b1;
      rst_tck_n <= rst_meta;
    end
  end

  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      hold_meta <= 1'b0;
      hold_sync <= 1'b0;
    end else begin
      hold_meta <= ctrl_hold;
      hold_sync <= hold_meta;
    end
  end

  // ----------------------------------------------------------------
  // Observed values into tck
  // ----------------------------------------------------------------
  // Bits sampled one by one; a word caught mid-change is tolerated,
  // capture is a snapshot of pins that the user keeps steady
  logic [CHAIN_LEN-1:0] obs_raw;
  logic [CHAIN_LEN-1:0] obs_meta;
  logic [CHAIN_LEN-1:0] obs_sync;

  assign obs_raw[POS_A_OE_N] = out_en_n_byte_a;
  assign obs_raw[POS_A_CLK]  = clk_byte_a;
  assign obs_raw[POS_A_EN]   = sys_en_a;
  assign obs_raw[POS_B_OE_N] = out_en_n_byte_b;
  assign obs_raw[POS_B_CLK]  = clk_byte_b;
  assign obs_raw[POS_B_EN]   = sys_en_b;

  for (genvar i = 0; i < BYTE_W; i++) begin : g_obs
    assign obs_raw[POS_A_IN_HI - i]  = din_byte_a[i];
    assign obs_raw[POS_B_IN_HI - i]  = din_byte_b[i];
    assign obs_raw[POS_A_OUT_HI - i] = q_a[i];
    assign obs_raw[POS_B_OUT_HI - i] = q_b[i];
  end

  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      obs_meta <= '0;
      obs_sync <= '0;
    end else begin
      obs_meta <= obs_raw;
      obs_sync <= obs_meta;
    end
  end

  // ----------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------
  tap_state_e state;
  tap_state_e fsm_next;

  always_comb begin
    fsm_next = state;
    unique case (state)
      TLR:      fsm_next = tms ? TLR      : RTI;
      RTI:      fsm_next = tms ? SEL_DR   : RTI;
      SEL_DR:   fsm_next = tms ? SEL_IR   : CAP_DR;
      CAP_DR:   fsm_next = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: fsm_next = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: fsm_next = tms ? UPD_DR   : PAUSE_DR;
      PAUSE_DR: fsm_next = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: fsm_next = tms ? UPD_DR   : SHIFT_DR;
      UPD_DR:   fsm_next = tms ? SEL_DR   : RTI;
      SEL_IR:   fsm_next = tms ? TLR      : CAP_IR;
      CAP_IR:   fsm_next = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: fsm_next = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: fsm_next = tms ? UPD_IR   : PAUSE_IR;
      PAUSE_IR: fsm_next = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: fsm_next = tms ? UPD_IR   : SHIFT_IR;
      UPD_IR:   fsm_next = tms ? SEL_DR   : RTI;
    endcase
  end

  // Software hold acts like a reset pin, but only while tck runs
  wire tap_state_e next_state = hold_sync ? TLR : fsm_next;

  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      state <= TLR;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Instruction, bypass and boundary registers
  // ----------------------------------------------------------------
  logic [IR_W-1:0]      ir_shift;
  logic [IR_W-1:0]      ir_hold;
  logic                 bypass_bit;
  logic [CHAIN_LEN-1:0] chain_shift;
  logic [CHAIN_LEN-1:0] chain_upd;

  wire instr_mode_e mode     = decode_instr(ir_hold);
  wire              bsr_sel  = (mode == MODE_EXTEST) |
                               (mode == MODE_SAMPLE);
  wire              goes_tlr = (next_state == TLR) & (state != TLR);
  wire              upd_evt  = (state == UPD_IR) | (state == UPD_DR) |
                               goes_tlr;
  wire              dr_bit   = bsr_sel ? chain_shift[0] : bypass_bit;
  wire              next_tdo = (state == SHIFT_IR) ? ir_shift[0] : dr_bit;
  wire              shifting = (state == SHIFT_IR) | (state == SHIFT_DR);

  // Reset instruction is bypass, so outputs return to system control
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      ir_shift <= OP_RESET;
      ir_hold  <= OP_RESET;
    end else begin
      if (state == CAP_IR) begin
        ir_shift <= IR_CAPTURE;
      end else if (state == SHIFT_IR) begin
        ir_shift <= {tdi, ir_shift[IR_W-1:1]};
      end
      if (goes_tlr) begin
        ir_hold <= OP_RESET;
      end else if (state == UPD_IR) begin
        ir_hold <= ir_shift;
      end
    end
  end

  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      bypass_bit  <= 1'b0;
      chain_shift <= '0;
      chain_upd   <= '0;
    end else begin
      if (state == CAP_DR) begin
        bypass_bit <= 1'b0;
      end else if (state == SHIFT_DR) begin
        bypass_bit <= tdi;
      end
      if (bsr_sel & (state == CAP_DR)) begin
        chain_shift <= obs_sync;
      end else if (bsr_sel & (state == SHIFT_DR)) begin
        chain_shift <= {tdi, chain_shift[CHAIN_LEN-1:1]};
      end
      if (bsr_sel & (state == UPD_DR)) begin
        chain_upd <= chain_shift;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control word toward pclk
  // ----------------------------------------------------------------
  // Update cells keep their values across Test-Logic-Reset
  assign ctl_tck.mode = mode;
  assign ctl_tck.en_a = chain_upd[POS_A_EN];
  assign ctl_tck.en_b = chain_upd[POS_B_EN];

  for (genvar i = 0; i < BYTE_W; i++) begin : g_ctl
    assign ctl_tck.out_a[i] = chain_upd[POS_A_OUT_HI - i];
    assign ctl_tck.out_b[i] = chain_upd[POS_B_OUT_HI - i];
  end

  // One toggle per update; the word stands until the next one
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      upd_toggle <= 1'b0;
    end else if (upd_evt) begin
      upd_toggle <= ~upd_toggle;
    end
  end

  // ----------------------------------------------------------------
  // Test data out on the falling edge
  // ----------------------------------------------------------------
  // Falling edge gives the controller half a period of hold
  always_ff @(negedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= next_tdo;
      tdo_oe <= shifting;
    end
  end

endmodule

// ---- design/scan_reg_pkg.sv ----
/*
  Constants, types and decode shared by the dual byte register with scan.
  Assumes one system clock (pclk) and one test clock (tck), unrelated.
*/
package scan_reg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BYTE_W    = 9;
  localparam int CHAIN_LEN = 42;
  localparam int IR_W      = 8;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  // Upper six bits arbitrary, low two bits fixed at 01
  localparam logic [7:0] IR_CAPTURE = 8'h95;
  localparam logic [7:0] OP_EXTEST  = 8'h00;
  localparam logic [7:0] OP_SAMPLE  = 8'h81;
  localparam logic [7:0] OP_CLAMP   = 8'h82;
  localparam logic [7:0] OP_HIGHZ   = 8'h03;
  localparam logic [7:0] OP_RESET   = 8'hff;

  // ----------------------------------------------------------------
  // Boundary chain positions
  // ----------------------------------------------------------------
  localparam int POS_A_OE_N   = 41;
  localparam int POS_A_CLK    = 40;
  localparam int POS_A_EN     = 39;
  localparam int POS_B_OE_N   = 38;
  localparam int POS_B_CLK    = 37;
  localparam int POS_B_EN     = 36;
  localparam int POS_A_IN_HI  = 35;
  localparam int POS_B_IN_HI  = 26;
  localparam int POS_A_OUT_HI = 17;
  localparam int POS_B_OUT_HI = 8;

  // ----------------------------------------------------------------
  // APB map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_BYTE_A = 12'h008;
  localparam logic [11:0] ADDR_BYTE_B = 12'h00c;
  localparam logic        CTRL_RESET  = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_EXTEST, MODE_SAMPLE, MODE_CLAMP, MODE_HIGHZ, MODE_BYPASS
  } instr_mode_e;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_e;

  typedef struct packed {
    instr_mode_e       mode;
    logic              en_a;
    logic              en_b;
    logic [BYTE_W-1:0] out_a;
    logic [BYTE_W-1:0] out_b;
  } test_ctl_s;

  localparam test_ctl_s CTL_RESET = '{MODE_BYPASS, 1'b0, 1'b0,
                                      9'h000, 9'h000};

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  function automatic instr_mode_e decode_instr(input logic [7:0] code);
    instr_mode_e m;
    m = MODE_BYPASS;
    if (code == OP_EXTEST) m = MODE_EXTEST;
    if (code == OP_SAMPLE) m = MODE_SAMPLE;
    if (code == OP_CLAMP)  m = MODE_CLAMP;
    if (code == OP_HIGHZ)  m = MODE_HIGHZ;
    return m;
  endfunction

endpackage

// ---- design/byte_register.sv ----
/*
  One nine-bit data register with its three-state output stage.
  Assumes pins asynchronous to pclk; test control already on pclk.
*/
`timescale 1ns/1ps
module byte_register (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            clk_pin,
  input  wire logic                            oe_n_pin,
  input  wire logic [scan_reg_pkg::BYTE_W-1:0] din_pin,
  input  wire logic                            test_drive,
  input  wire logic                            test_float,
  input  wire logic                            test_en,
  input  wire logic [scan_reg_pkg::BYTE_W-1:0] test_val,
  output logic      [scan_reg_pkg::BYTE_W-1:0] q,
  output logic                                 sys_en,
  output logic      [scan_reg_pkg::BYTE_W-1:0] dout,
  output logic                                 dout_oe
);
  import scan_reg_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic              clk_meta;
  logic              clk_sync;
  logic              clk_prev;
  logic              oe_meta;
  logic              oe_sync;
  logic [BYTE_W-1:0] din_meta;
  logic [BYTE_W-1:0] din_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
      oe_meta  <= 1'b1;
      oe_sync  <= 1'b1;
      din_meta <= 9'h000;
      din_sync <= 9'h000;
    end else begin
      clk_meta <= clk_pin;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      oe_meta  <= oe_n_pin;
      oe_sync  <= oe_meta;
      din_meta <= din_pin;
      din_sync <= din_meta;
    end
  end

  // ----------------------------------------------------------------
  // Storage and output stage
  // ----------------------------------------------------------------
  // Data shares the clock's sync delay, so setup is kept at the pins
  wire               clk_rise = clk_sync & ~clk_prev;
  wire               en_sys   = ~oe_sync;
  wire [BYTE_W-1:0]  next_q   = clk_rise ? din_sync : q;
  wire [BYTE_W-1:0]  next_dout = test_drive ? test_val : q;
  wire               next_oe  = test_float ? 1'b0 :
                                test_drive ? test_en : en_sys;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= 9'h000;
      sys_en  <= 1'b0;
      dout    <= 9'h000;
      dout_oe <= 1'b0;
    end else begin
      q       <= next_q;
      sys_en  <= en_sys;
      dout    <= next_dout;
      dout_oe <= next_oe;
    end
  end

endmodule

// ---- test/scan_reg_assertions.sv ----
/*
  Port-level assertions for the dual byte register with scan.
  Assumes binding to the top; mode is learnt from status reads.
*/
`timescale 1ns/1ps
module scan_reg_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clk_byte_a,
  input wire logic        clk_byte_b,
  input wire logic        out_en_n_byte_a,
  input wire logic        out_en_n_byte_b,
  input wire logic [8:0]  din_byte_a,
  input wire logic [8:0]  dout_byte_a,
  input wire logic [8:0]  dout_byte_b,
  input wire logic        dout_oe_a,
  input wire logic        dout_oe_b,
  input wire logic        tck,
  input wire logic        tdo,
  input wire logic        tdo_oe
);
  import scan_reg_pkg::*;
  logic sys_ok;
  wire  unmapped = paddr[1:0] != 2'h0 || paddr > ADDR_BYTE_B;
  wire  st_rd = psel && penable && pready && !pwrite && paddr == ADDR_STATUS;
  // Any tck activity may change mode, so trust only a fresh read
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) sys_ok <= 1'b0;
    else if ($changed(tck)) sys_ok <= 1'b0;
    else if (st_rd) sys_ok <= prdata[2:0] == 3'h1 || prdata[2:0] == 3'h4;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence a_load_s; sys_ok && $rose(clk_byte_a); endsequence
  ready_after_setup_a:
    assert property (setup_s |=> pready) else $error("no pready");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready too long");
  err_decode_a:
    assert property (setup_s |=> pslverr == $past(unmapped))
    else $error("pslverr wrong for address");
  oe_float_a:
    assert property ((sys_ok && out_en_n_byte_a)[*4] |-> !dout_oe_a)
    else $error("byte a driven with enable pin high");
  oe_drive_b_a:
    assert property ((sys_ok && !out_en_n_byte_b)[*4] |-> dout_oe_b)
    else $error("byte b not driven with enable pin low");
  load_dout_a:
    assert property (a_load_s |-> ##4 dout_byte_a == $past(din_byte_a, 4))
    else $error("byte a did not load its inputs");
  oe_keeps_b_a:
    assert property ((sys_ok && !clk_byte_b)[*8] ##0
      $changed(out_en_n_byte_b) |=> $stable(dout_byte_b)[*4])
    else $error("enable change altered byte b");
  tdo_fall_a:
    assert property ($changed(tdo) || $changed(tdo_oe) |-> !tck)
    else $error("tdo moved while tck high");
endmodule

bind dual_byte_register_with_scan scan_reg_assertions u_scan_reg_assertions (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .clk_byte_a(clk_byte_a), .clk_byte_b(clk_byte_b),
  .out_en_n_byte_a(out_en_n_byte_a), .out_en_n_byte_b(out_en_n_byte_b),
  .din_byte_a(din_byte_a), .dout_byte_a(dout_byte_a),
  .dout_byte_b(dout_byte_b), .dout_oe_a(dout_oe_a), .dout_oe_b(dout_oe_b),
  .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe));

// ---- test/scan_ctl_model.sv ----
/*
  Test controller model: drives tck, tms, tdi and samples tdo.
  Assumes the device TAP rests in Run-Test-Idle between frames.
*/
`timescale 1ns/1ps
module scan_ctl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 80 ns period; tck stands still outside frames
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #40;
    o = tdo;
    tck = 1'b1;
    #40;
    tck = 1'b0;
  endtask
  task automatic reset_tap();
    logic o;
    #7;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // Idle clocks in Run-Test-Idle let a software hold reach the TAP
  task automatic run(input int n);
    logic o;
    #7;
    repeat (n) step(1'b0, 1'b0, o);
  endtask
  // Odd start offset keeps tck edges off the pclk grid
  task automatic shift(input logic ir, input logic [41:0] d, input int n,
                       output logic [41:0] q);
    logic o;
    q = '0;
    #7;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule

// ---- test/tb.sv ----
/*
  Self-checking bench: APB master, byte pins, scan frames via the model.
  Assumes the package, the checker bind and the model compiled first.
*/
`timescale 1ns/1ps
module tb;
  import scan_reg_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, clk_a = 1'b0, clk_b = 1'b0;
  logic        oe_n_a = 1'b0, oe_n_b = 1'b1, pready, pslverr, oe_a, oe_b;
  logic        tck, tms, tdi, tdo, tdo_oe;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [8:0]  din_a = 9'h1a5, din_b = 9'h05a, dout_a, dout_b;
  int          err_count = 0, n_compared = 0;
  wire         tdo_w = tdo_oe ? tdo : 1'bz;
  logic [7:0]  codes [5] = '{OP_SAMPLE, OP_EXTEST, OP_CLAMP, OP_HIGHZ, 8'h55};
  instr_mode_e modes [5] = '{MODE_SAMPLE, MODE_EXTEST, MODE_CLAMP,
                             MODE_HIGHZ, MODE_BYPASS};
  always #10 pclk = ~pclk;
  dual_byte_register_with_scan u_dual_byte_register_with_scan (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clk_byte_a(clk_a),
    .clk_byte_b(clk_b), .out_en_n_byte_a(oe_n_a), .out_en_n_byte_b(oe_n_b),
    .din_byte_a(din_a), .din_byte_b(din_b), .dout_byte_a(dout_a),
    .dout_byte_b(dout_b), .dout_oe_a(oe_a), .dout_oe_b(oe_b), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  scan_ctl_model u_scan_ctl_model (.tck(tck), .tms(tms), .tdi(tdi),
                                   .tdo(tdo_w));
  task automatic chk(input logic [41:0] got, input logic [41:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(42'(r), 42'(x));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  function automatic logic [41:0] chain(input logic [5:0] c,
      input logic [8:0] ia, input logic [8:0] ib, input logic [8:0] oa,
      input logic [8:0] ob);
    logic [41:0] v;
    v[41:36] = c;
    for (int i = 0; i < 9; i++) begin
      v[35-i] = ia[i];
      v[26-i] = ib[i];
      v[17-i] = oa[i];
      v[8-i] = ob[i];
    end
    return v;
  endfunction
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [41:0] q;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    u_scan_ctl_model.reset_tap();
    rd(ADDR_STATUS, 33'(MODE_BYPASS));
    rd(ADDR_CTRL, 33'h0);
    rd(12'h010, 33'h1_0000_0000);
    wr(ADDR_BYTE_A, 32'h1ff);
    rd(ADDR_BYTE_A, 33'h0);
    $display("test registers done");
    clk_a <= 1'b1;
    repeat (4) @(posedge pclk);
    clk_a <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(ADDR_BYTE_A, 33'h1a5);
    rd(ADDR_BYTE_B, 33'h0);
    chk({oe_a, oe_b, dout_a}, {2'b10, 9'h1a5});
    oe_n_b <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(oe_b, 1'b1);
    oe_n_b <= 1'b1;
    oe_n_a <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({oe_a, oe_b, dout_a}, {2'b00, 9'h1a5});
    rd(ADDR_BYTE_A, 33'h1a5);
    oe_n_a <= 1'b0;
    $display("test byte pins done");
    for (int i = 0; i < 5; i++) begin
      u_scan_ctl_model.shift(1'b1, 42'(codes[i]), 8, q);
      chk(q, 42'(IR_CAPTURE));
      repeat (8) @(posedge pclk);
      // Enable cells are preloaded high by step 0 and keep that value
      rd(ADDR_STATUS, {28'h0, {2{i > 0}}, modes[i]});
      case (i)
        0: begin
          u_scan_ctl_model.shift(1'b0,
            chain(6'b001001, 9'h0, 9'h0, 9'h0f0, 9'h10f), 42, q);
          chk(q, chain(6'b001100, 9'h1a5, 9'h05a, 9'h1a5, 9'h0));
        end
        1: chk({oe_a, oe_b, dout_a, dout_b},
               {2'b11, 9'h0f0, 9'h10f});
        2: begin
          u_scan_ctl_model.shift(1'b0, 42'h1, 2, q);
          chk({q[1:0], oe_a, dout_a}, {3'b101, 9'h0f0});
        end
        3: begin
          chk({oe_a, oe_b}, 2'b00);
          wr(ADDR_CTRL, 32'h1);
          rd(ADDR_CTRL, 33'h1);
          u_scan_ctl_model.run(4);
          repeat (8) @(posedge pclk);
          rd(ADDR_STATUS, {28'h0, 2'b11, MODE_BYPASS});
          wr(ADDR_CTRL, 32'h0);
          u_scan_ctl_model.reset_tap();
        end
        default: chk({oe_a, dout_a}, {1'b1, 9'h1a5});
      endcase
      $display("test scan step %0d done", i);
    end
    conclude();
  end
  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule
